// *** hdl/tbu_defines.svh ***
// Field positions and constants of the transmit buffer unpacker
`ifndef TBU_DEFINES_SVH
`define TBU_DEFINES_SVH
// ----------------------------------------
// First command word
// ----------------------------------------
`define TBU_A_SIZE_HI 10
`define TBU_A_SIZE_LO 0
`define TBU_A_LS_BIT 12
`define TBU_A_FS_BIT 13
`define TBU_A_OFF_HI 21
`define TBU_A_OFF_LO 16
`define TBU_A_ALIGN_HI 25
`define TBU_A_ALIGN_LO 24
// ----------------------------------------
// Second command word
// ----------------------------------------
`define TBU_B_LEN_HI 10
`define TBU_B_LEN_LO 0
`define TBU_B_NOPAD_BIT 12
`define TBU_B_NOCRC_BIT 13
`define TBU_B_TAG_HI 31
`define TBU_B_TAG_LO 16
// ----------------------------------------
// End alignment codes and masks, in words
// ----------------------------------------
`define TBU_ALIGN_4 2'h0
`define TBU_ALIGN_16 2'h1
`define TBU_ALIGN_32 2'h2
`define TBU_MASK_4 3'h0
`define TBU_MASK_16 3'h3
`define TBU_MASK_32 3'h7
`define TBU_LANE_LAST 2'h3
`endif

// *** hdl/tbu_pkg.sv ***
// Types shared by the transmit buffer unpacker
`default_nettype none
package tbu_pkg;
  typedef enum logic [2:0] {
    TBU_CMDA = 3'h0,
    TBU_CMDB = 3'h1,
    TBU_SKIP = 3'h3,
    TBU_DATA = 3'h2,
    TBU_PAD = 3'h6
  } tbu_state_t;

  typedef struct packed {
    logic last;
    logic [7:0] data;
  } tbu_byte_t;

  typedef struct packed {
    logic [15:0] tag;
    logic add_fcs;
    logic pad_en;
    logic [10:0] length;
  } tbu_pkt_ctl_t;
endpackage
`default_nettype wire

// *** hdl/tbu_unpacker.sv ***
// Transmit buffer command unpacker: data FIFO words in, payload bytes out
`include "tbu_defines.svh"
`default_nettype none

// Notes on behaviour
// - Tag of second command word is copied into the transmit status tag.
// - Second word bit 13 set: no frame check sequence appended, unless bit 12 is also set.
// - Second word bit 12 set: no short-frame padding, frame check sequence kept.
// - Packet length compared with bytes supplied; mismatch sets error flag.
// - Buffer is first command, second command, then data words.
// - Two low offset bits select the first valid byte lane.
// - Offset bits 5:2 give whole words discarded before data.
// - Data contiguous, may end on any byte; unused trailing bytes withheld.
// - End alignment of 4, 16 or 32 bytes; filler words removed.
// - Offset plus buffer size with alignment gives filler count; running size total kept.
// - First command bit 13 marks first segment, bit 12 last.
// - Second command word present only when first-segment bit set.
module tbu_unpacker
  import tbu_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [31:0] fifo_word,
  input wire logic fifo_valid,
  output logic fifo_ready,
  output var tbu_byte_t mac_transmit_path,
  output logic mac_valid,
  input wire logic mac_ready,
  output var tbu_pkt_ctl_t pkt_ctl,
  output logic [15:0] status_tag,
  output logic status_valid,
  output logic transmit_error_flag,
  input wire logic error_clear
);
  // ----------------------------------------
  // Word holding register
  // ----------------------------------------
  tbu_state_t state;
  tbu_state_t next_state;
  logic [31:0] word;
  logic word_full;
  logic next_word_full;
  logic word_done;
  logic take_word;
  logic [10:0] size;
  logic [5:0] offset;
  logic [1:0] align;
  logic last_seg;
  logic first_segment_bit;
  logic [3:0] skip_left;
  logic [2:0] pad_left;
  logic [10:0] bytes_left;
  logic [1:0] lane;
  logic [11:0] total;
  tbu_byte_t skid;
  logic skid_valid;

  assign take_word = fifo_valid && fifo_ready;
  assign next_word_full = (word_full && !word_done) || take_word;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      word <= 32'h0000_0000;
      word_full <= 1'b0;
      fifo_ready <= 1'b0;
    end else begin
      if (take_word) begin
        word <= fifo_word;
      end
      word_full <= next_word_full;
      fifo_ready <= !next_word_full; // Registered ready costs a bubble per word
    end
  end

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  wire is_cmda = state == TBU_CMDA && word_full;
  wire is_cmdb = state == TBU_CMDB && word_full;
  wire a_fs = word[`TBU_A_FS_BIT];
  wire [5:0] a_off = word[`TBU_A_OFF_HI:`TBU_A_OFF_LO];
  wire [10:0] a_size = word[`TBU_A_SIZE_HI:`TBU_A_SIZE_LO];
  wire [1:0] a_align = word[`TBU_A_ALIGN_HI:`TBU_A_ALIGN_LO];
  wire b_nopad = word[`TBU_B_NOPAD_BIT];
  wire b_nocrc = word[`TBU_B_NOCRC_BIT];

  // Filler words: round the used words up to the alignment
  wire [11:0] used_bytes = {6'h00, offset} + {1'b0, size};
  wire [9:0] used_words = used_bytes[11:2] + {9'h000, |used_bytes[1:0]};
  wire [2:0] align_mask = (align == `TBU_ALIGN_16) ? `TBU_MASK_16 :
                          (align == `TBU_ALIGN_32) ? `TBU_MASK_32 : `TBU_MASK_4;
  wire [2:0] pad_words = (3'h0 - used_words[2:0]) & align_mask;

  // ----------------------------------------
  // Byte emission
  // ----------------------------------------
  wire in_data = state == TBU_DATA && word_full;
  wire emit = in_data && !skid_valid;
  wire last_byte = bytes_left == 11'h001;
  wire skip_step = state == TBU_SKIP && skip_left != 4'h0;
  wire pad_step = state == TBU_PAD && pad_left != 3'h0;
  wire buf_end = state == TBU_PAD && pad_left == 3'h0;
  tbu_byte_t next_byte;
  assign next_byte.data = word[{lane, 3'h0} +: 8];
  assign next_byte.last = last_byte && last_seg;
  assign word_done = is_cmda || is_cmdb || (word_full && (skip_step || pad_step))
                     || (emit && (lane == `TBU_LANE_LAST || last_byte));

  always_comb begin
    next_state = state;
    unique case (state)
      TBU_CMDA: begin
        if (is_cmda) begin
          next_state = a_fs ? TBU_CMDB : TBU_SKIP;
        end
      end
      TBU_CMDB: begin
        if (is_cmdb) begin
          next_state = TBU_SKIP;
        end
      end
      TBU_SKIP: begin
        if (skip_left == 4'h0) begin
          next_state = (size != 11'h000) ? TBU_DATA : TBU_PAD;
        end
      end
      TBU_DATA: begin
        if (emit && last_byte) begin
          next_state = TBU_PAD;
        end
      end
      TBU_PAD: begin
        if (buf_end) begin
          next_state = TBU_CMDA;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state <= TBU_CMDA;
      size <= 11'h000;
      offset <= 6'h00;
      align <= 2'h0;
      last_seg <= 1'b0;
      first_segment_bit <= 1'b0;
    end else begin
      state <= next_state;
      if (is_cmda) begin
        size <= a_size;
        offset <= a_off;
        align <= a_align;
        last_seg <= word[`TBU_A_LS_BIT];
        first_segment_bit <= a_fs;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      skip_left <= 4'h0;
      pad_left <= 3'h0;
      bytes_left <= 11'h000;
      lane <= 2'h0;
    end else begin
      if (is_cmda) begin
        skip_left <= a_off[5:2];
      end else if (skip_step && word_full) begin
        skip_left <= skip_left - 4'h1;
      end
      if (state == TBU_SKIP && skip_left == 4'h0) begin
        bytes_left <= size;
        lane <= offset[1:0];
        pad_left <= pad_words;
      end else if (emit) begin
        bytes_left <= bytes_left - 11'h001;
        lane <= lane + 2'h1;
      end else if (pad_step && word_full) begin
        pad_left <= pad_left - 3'h1;
      end
    end
  end

  // ----------------------------------------
  // Packet control, running total, error
  // ----------------------------------------
  wire [11:0] next_total = (is_cmda && a_fs) ? {1'b0, a_size} : total + {1'b0, a_size};
  wire len_bad = buf_end && last_seg && total != {1'b0, pkt_ctl.length};

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pkt_ctl <= '0;
      total <= 12'h000;
      status_tag <= 16'h0000;
      status_valid <= 1'b0;
      transmit_error_flag <= 1'b0;
    end else begin
      if (is_cmda) begin
        total <= next_total;
      end
      if (is_cmdb) begin
        pkt_ctl.tag <= word[`TBU_B_TAG_HI:`TBU_B_TAG_LO];
        pkt_ctl.add_fcs <= b_nopad || !b_nocrc;
        pkt_ctl.pad_en <= !b_nopad;
        pkt_ctl.length <= word[`TBU_B_LEN_HI:`TBU_B_LEN_LO];
      end
      status_valid <= buf_end && last_seg;
      if (buf_end && last_seg) begin
        status_tag <= pkt_ctl.tag;
      end
      // Set wins over a clear in the same cycle
      if (len_bad) begin
        transmit_error_flag <= 1'b1;
      end else if (error_clear) begin
        transmit_error_flag <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Two-entry output buffer
  // ----------------------------------------
  wire pop = mac_valid && mac_ready;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      mac_transmit_path <= '0;
      mac_valid <= 1'b0;
      skid <= '0;
      skid_valid <= 1'b0;
    end else if (pop || !mac_valid) begin
      if (skid_valid) begin
        mac_transmit_path <= skid;
        mac_valid <= 1'b1;
        skid_valid <= emit;
        skid <= next_byte;
      end else begin
        mac_transmit_path <= next_byte;
        mac_valid <= emit;
      end
    end else if (emit) begin
      skid <= next_byte;
      skid_valid <= 1'b1;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence s_cmda_fs;
    state == TBU_CMDA && word_full && word[`TBU_A_FS_BIT];
  endsequence
  sequence s_cmda_nofs;
    state == TBU_CMDA && word_full && !word[`TBU_A_FS_BIT];
  endsequence

  a_tag_copy: assert property (
    buf_end && last_seg |=> status_valid && status_tag == $past(pkt_ctl.tag))
    else $error("status tag not copied");
  a_crc_off: assert property (
    is_cmdb && b_nocrc && !b_nopad |=> !pkt_ctl.add_fcs)
    else $error("frame check sequence not disabled");
  a_nopad_crc: assert property (
    is_cmdb && b_nopad |=> pkt_ctl.add_fcs && !pkt_ctl.pad_en)
    else $error("no-pad frame lost its check sequence");
  a_len_error: assert property (
    len_bad |=> transmit_error_flag)
    else $error("length mismatch not flagged");
  a_cmd_order: assert property (
    s_cmda_fs |=> state == TBU_CMDB)
    else $error("second command word not expected");
  a_cmdb_only_fs: assert property (
    s_cmda_nofs |=> state == TBU_SKIP)
    else $error("second command word taken without first segment");
  a_cmdb_after_fs: assert property (
    state == TBU_CMDB |-> first_segment_bit)
    else $error("second command word awaited without first segment");
  a_first_lane: assert property (
    $rose(state == TBU_DATA) |-> lane == offset[1:0])
    else $error("wrong first byte lane");
  a_skip_words: assert property (
    is_cmda ##1 (state != TBU_DATA) [*1] |-> skip_left == $past(a_off[5:2]))
    else $error("skip count wrong");
  a_trail_held: assert property (
    emit && last_byte |=> state == TBU_PAD && !word_full)
    else $error("trailing bytes not withheld");
  a_pad_bound: assert property (
    state == TBU_PAD |-> pad_left <= align_mask)
    else $error("filler count beyond alignment");
  a_total_fs: assert property (
    s_cmda_fs |=> total == {1'b0, size})
    else $error("running total not restarted");
  a_err_sticky: assert property (
    transmit_error_flag && !error_clear |=> transmit_error_flag)
    else $error("error flag dropped without clear");
  a_buf_hold: assert property (
    mac_valid && !mac_ready |=> mac_valid && $stable(mac_transmit_path))
    else $error("output byte changed while stalled");
endmodule // tbu_unpacker
`default_nettype wire

// *** testbench/tbu_host_model.sv ***
// Host model that writes transmit buffers into the data FIFO
`default_nettype none
module tbu_host_model (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic fifo_ready,
  output logic [31:0] fifo_word,
  output logic fifo_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  // Words queued by the bench in buffer order: A, B if first, skipped words, data, filler
  logic [31:0] q[$];
  task automatic push(input logic [31:0] w);
    q.push_back(w);
  endtask
  // Word held until taken; random gaps so the FIFO is sometimes slow
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      fifo_valid <= 1'b0;
      fifo_word <= 32'h0000_0000;
    end else if (!(fifo_valid && !fifo_ready)) begin
      if (fifo_valid) void'(q.pop_front());
      if (q.size() > 0 && ($urandom % 4) != 0) begin
        fifo_valid <= 1'b1;
        fifo_word <= q[0];
      end else begin
        fifo_valid <= 1'b0;
        fifo_word <= ~fifo_word; // Stale word never looks valid
      end
    end
  end
endmodule // tbu_host_model
`default_nettype wire

// *** testbench/tbu_unpacker_tb.sv ***
// Self-checking bench for the transmit buffer unpacker
`default_nettype none
module tbu_unpacker_tb;
  import tbu_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic mac_ready = 1'b0;
  logic error_clear = 1'b0;
  logic [31:0] fifo_word;
  logic fifo_valid, fifo_ready, mac_valid, status_valid, transmit_error_flag;
  tbu_byte_t mac_transmit_path;
  tbu_pkt_ctl_t pkt_ctl;
  logic [15:0] status_tag;
  logic [8:0] exp_q[$];
  logic [15:0] exp_tag;
  logic exp_err, stall;
  logic hung = 1'b0;
  int n_status = 0;
  int n_errors = 0;
  int compares = 0;
  // ----------------------------------------
  // Design and host
  // ----------------------------------------
  tbu_unpacker dut (.clk_sys(clk_sys), .resetn(resetn), .fifo_word(fifo_word),
    .fifo_valid(fifo_valid), .fifo_ready(fifo_ready), .mac_transmit_path(mac_transmit_path),
    .mac_valid(mac_valid), .mac_ready(mac_ready), .pkt_ctl(pkt_ctl), .status_tag(status_tag),
    .status_valid(status_valid), .transmit_error_flag(transmit_error_flag),
    .error_clear(error_clear));
  tbu_host_model host (.clk_sys(clk_sys), .resetn(resetn), .fifo_ready(fifo_ready),
    .fifo_word(fifo_word), .fifo_valid(fifo_valid));
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  // ----------------------------------------
  // Checking
  // ----------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] want);
    compares++;
    if (got !== want) begin
      n_errors++;
      $display("BAD t=%0t seen=%h expected=%h", $time, got, want);
    end
  endtask
  task automatic summarize();
    if (n_errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Receiver stalls hard on packets 4 to 7 and 12 to 15 to fill the buffer
  always @(posedge clk_sys) begin
    mac_ready <= stall ? ($urandom % 8 == 0) : ($urandom % 4 != 0);
    if (resetn && mac_valid && mac_ready) begin
      check(32'(exp_q.size() > 0), 32'h0000_0001);
      check(32'(mac_transmit_path), 32'(exp_q.pop_front()));
    end
    if (resetn && status_valid) begin
      check(32'(status_tag), 32'(exp_tag));
      check(32'(transmit_error_flag), 32'(exp_err));
      n_status++;
    end
  end
  // ----------------------------------------
  // Buffer and packet builders
  // ----------------------------------------
  task automatic send_buf(input logic first, input logic last, input logic [5:0] off,
      input logic [1:0] align, input logic [10:0] size, input logic [31:0] cmd_b);
    int lane, nw, aw, fill;
    logic [31:0] w;
    lane = int'(off[1:0]);
    nw = (lane + int'(size) + 3) / 4;
    host.push({6'h00, align, 2'h0, off, 2'h0, first, last, 1'b0, size});
    if (first) host.push(cmd_b);
    for (int k = 0; k < int'(off[5:2]); k++) host.push($urandom());
    w = 32'h0000_0000;
    for (int k = 0; k < nw * 4; k++) begin
      if (k % 4 == 0) w = $urandom();
      if (k >= lane && k < lane + int'(size)) begin
        exp_q.push_back({last && (k == lane + int'(size) - 1), w[8 * (k % 4) +: 8]});
      end
      if (k % 4 == 3) host.push(w);
    end
    aw = (align == 2'h1) ? 4 : (align == 2'h2) ? 8 : 1;
    fill = (aw - ((int'(off) + int'(size) + 3) / 4) % aw) % aw;
    for (int k = 0; k < fill; k++) host.push($urandom());
  endtask
  task automatic run_pkt(input int i);
    int nb, total, n, st0;
    logic [10:0] sz[3];
    logic [10:0] len;
    logic nocrc, nopad;
    nb = 1 + i % 3;
    total = 0;
    for (int b = 0; b < nb; b++) begin
      sz[b] = 11'(4 + $urandom % 48);
      total += int'(sz[b]);
    end
    len = 11'(total + ((i % 5 == 3) ? 1 : 0));
    nocrc = i[0];
    nopad = i[1];
    exp_tag = 16'($urandom);
    exp_err = (i % 5 == 3);
    stall = i[2];
    st0 = n_status;
    for (int b = 0; b < nb; b++) begin
      send_buf(b == 0, b == nb - 1, 6'((i + b) % 4 + 4 * ($urandom % 8)), 2'((i + b) % 4),
        sz[b], {exp_tag, 2'h0, nocrc, nopad, 1'b0, len});
    end
    for (n = 0; n < 4000 && !(n_status != st0 && exp_q.size() == 0); n++) @(posedge clk_sys);
    if (n == 4000) begin
      n_errors++;
      hung = 1'b1;
      return;
    end
    check(32'(n_status - st0), 32'h0000_0001);
    check(32'(pkt_ctl), {3'h0, exp_tag, nopad || !nocrc, !nopad, len});
    repeat (3) @(posedge clk_sys);
    check(32'(transmit_error_flag), 32'(exp_err));
    error_clear <= 1'b1;
    @(posedge clk_sys);
    error_clear <= 1'b0;
    repeat (2) @(posedge clk_sys);
    check(32'(transmit_error_flag), 32'h0000_0000);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h0000_7b03));
    stall = 1'b0;
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (2) @(posedge clk_sys);
    for (int i = 0; i < 16 && !hung; i++) run_pkt(i);
    summarize();
  end
endmodule // tbu_unpacker_tb
`default_nettype wire
